//--- hw/hsp_pkg.sv
// constants, types and helpers for the host serial port and event unit
package hsp_pkg;
  // clock and half-symbol tick timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int HSYM_TICK_NS  = 8000;
  localparam int HSYM_TICK_CYC = HSYM_TICK_NS / CLK_PERIOD_NS;
  // short-space register indices (apb byte address is four times these)
  localparam logic [5:0] IDX_TXSTAT = 6'h24;
  localparam logic [5:0] IDX_TMR_LO = 6'h28;
  localparam logic [5:0] IDX_TMR_HI = 6'h29;
  localparam logic [5:0] IDX_STATUS = 6'h31;
  localparam logic [5:0] IDX_MASK   = 6'h32;
  localparam logic [5:0] IDX_CTRL   = 6'h3C;
  localparam logic [5:0] IDX_HDR    = 6'h3D;
  // reset values
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] MASK_RST   = 8'hFF;
  // event bit positions, shared by status and mask
  localparam int BIT_SLEEP = 7;
  localparam int BIT_WAKE  = 6;
  localparam int BIT_TMR   = 5;
  localparam int BIT_SEC   = 4;
  localparam int BIT_RX    = 3;
  localparam int BIT_SLOT2 = 2;
  localparam int BIT_SLOT1 = 1;
  localparam int BIT_NORM  = 0;
  // fixed upper part of the two-wire slave address
  localparam logic [4:0] SLAVE_ADDR_HI = 5'h19;
  // four-wire access header layout
  localparam int SHORT_FLAG_BIT = 7;
  localparam int LONG_FLAG_BIT  = 11;
  localparam logic [9:0] LONG_FIRST = 10'h200;
  localparam logic [9:0] LONG_LAST  = 10'h27F;

  // two-wire slave states
  typedef enum logic [3:0] {
    I_IDLE, I_ADDR, I_ACK_A, I_REG, I_ACK_R, I_WDATA, I_ACK_W, I_RDATA, I_RACK, I_WAIT
  } i2c_state_e;

  // decode a four-wire header into {valid, address, long, read_write}
  function automatic logic [12:0] decode_hdr(input logic [11:0] hdr);
    logic [9:0] a;
    logic       v;
    a = 10'h000;
    v = 1'b0;
    if (hdr[LONG_FLAG_BIT]) begin
      a = hdr[10:1];
      v = (a >= LONG_FIRST) && (a <= LONG_LAST);
    end else begin
      a = {4'h0, hdr[6:1]};
      v = (hdr[10:8] == 3'h0) && !hdr[SHORT_FLAG_BIT];
    end
    return {v, a, hdr[LONG_FLAG_BIT], hdr[0]};
  endfunction
endpackage

//--- hw/host_serial_port_and_irq.sv
// two-wire register slave, apb register slave, event flags and interrupt pin
module host_serial_port_and_irq
  import hsp_pkg::*;
#(
  parameter int TICK_CYCLES = HSYM_TICK_CYC  // clocks per half-symbol tick
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  input  wire logic        serial_clock_pin_i,
  input  wire logic        serial_enable_pin_i,
  input  wire logic        inactive_start_i,
  input  wire logic        wakeup_i,
  input  wire logic        rx_frame_i,
  input  wire logic        rx_secure_i,
  input  wire logic        rx_filter_pass_i,
  input  wire logic        slot2_done_i,
  input  wire logic        slot1_done_i,
  input  wire logic        normal_done_i,
  input  wire logic [4:0]  tx_result_i,
  output logic             irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    i2c_state_e  st;        // two-wire slave phase
    logic [2:0]  scl_sy;    // three-stage synchroniser, clock line
    logic [2:0]  sda_sy;    // three-stage synchroniser, data line
    logic [2:0]  sck_sy;    // strap pin synchroniser
    logic [2:0]  sen_sy;    // strap pin synchroniser
    logic        scl_f;     // agreed clock level
    logic        sda_f;     // agreed data level
    logic        sck_f;     // agreed strap level
    logic        sen_f;     // agreed strap level
    logic [7:0]  sh;        // shift register
    logic [3:0]  cnt;       // bit count within a byte
    logic        rw;        // direction of current transfer
    logic [7:0]  ptr;       // register pointer
    logic        sda_oe;    // pull data line low
    logic        sda_out;   // open-drain value, always low
    logic [7:0]  status;    // sticky event flags
    logic [7:0]  mask;      // event mask, 1 blocks
    logic        pol;       // 1 interrupt active high
    logic [4:0]  txstat;    // transmit release outcome
    logic [15:0] hsym;      // half_symbol_down_counter
    logic [7:0]  hsym_lo;   // low byte held until high byte loads
    logic [15:0] tick;      // half-symbol divider
    logic [11:0] hdr;       // four-wire header under decode
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        irq;
  } state_s;

  localparam state_s RESET = '{
    st: I_IDLE, scl_sy: 3'h7, sda_sy: 3'h7, sck_sy: 3'h0, sen_sy: 3'h0,
    scl_f: 1'b1, sda_f: 1'b1, sck_f: 1'b0, sen_f: 1'b0, sh: 8'h00,
    cnt: 4'h0, rw: 1'b0, ptr: 8'h00, sda_oe: 1'b0, sda_out: 1'b0,
    status: STATUS_RST, mask: MASK_RST, pol: 1'b0, txstat: 5'h00,
    hsym: 16'h0000, hsym_lo: 8'h00, tick: 16'h0000, hdr: 12'h000,
    pready: 1'b0, prdata: 32'h0000_0000, pslverr: 1'b0, irq: 1'b1
  };

  state_s s;          // registered state
  state_s n;          // next state
  logic [7:0] ev;     // event pulses this cycle
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;
  logic       tk;     // half-symbol tick
  logic       tmr_zero;
  logic       apb_done;
  logic       clr;    // status read this cycle
  logic       match;  // address byte matches
  logic [7:0] d;      // byte loaded for shifting out
  logic       nscl;
  logic       nsda;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // register read view, shared by both hosts
  function automatic logic [7:0] reg_rd(input state_s x, input logic [5:0] idx);
    logic [12:0] h;
    h = decode_hdr(x.hdr);
    unique case (idx)
      IDX_TXSTAT: reg_rd = {3'h0, x.txstat};
      IDX_TMR_LO: reg_rd = x.hsym[7:0];
      IDX_TMR_HI: reg_rd = x.hsym[15:8];
      IDX_STATUS: reg_rd = x.status;
      IDX_MASK:   reg_rd = x.mask;
      IDX_CTRL:   reg_rd = {7'h00, x.pol};
      IDX_HDR:    reg_rd = h[7:0];
      default:    reg_rd = 8'h00;
    endcase
  endfunction

  // which indices answer on the apb side
  function automatic logic reg_known(input logic [5:0] idx);
    return idx inside {IDX_TXSTAT, IDX_TMR_LO, IDX_TMR_HI, IDX_STATUS,
                       IDX_MASK, IDX_CTRL, IDX_HDR};
  endfunction

  // write effect of one byte; status and tx status are read-only
  function automatic state_s reg_wr(input state_s x, input logic [5:0] idx,
                                    input logic [7:0] v);
    state_s y;
    y = x;
    unique case (idx)
      IDX_TMR_LO: y.hsym_lo = v;
      IDX_TMR_HI: y.hsym = {v, x.hsym_lo};
      IDX_MASK:   y.mask = v;
      IDX_CTRL:   y.pol = v[0];
      default:    y = x;
    endcase
    return y;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  // one process for all behaviour; the register stage below stores it
  always_comb begin
    n        = s;
    tk       = 1'b0;
    tmr_zero = 1'b0;
    clr      = 1'b0;
    d        = 8'h00;
    // first stage feeds only the second; levels count once stages 2 and 3 agree
    n.scl_sy = {s.scl_sy[1:0], scl_i};
    n.sda_sy = {s.sda_sy[1:0], sda_i};
    n.sck_sy = {s.sck_sy[1:0], serial_clock_pin_i};
    n.sen_sy = {s.sen_sy[1:0], serial_enable_pin_i};
    nscl     = (s.scl_sy[1] == s.scl_sy[2]) ? s.scl_sy[2] : s.scl_f;
    nsda     = (s.sda_sy[1] == s.sda_sy[2]) ? s.sda_sy[2] : s.sda_f;
    n.scl_f  = nscl;
    n.sda_f  = nsda;
    if (s.sck_sy[1] == s.sck_sy[2]) begin
      n.sck_f = s.sck_sy[2];
    end
    if (s.sen_sy[1] == s.sen_sy[2]) begin
      n.sen_f = s.sen_sy[2];
    end
    scl_rise = nscl & ~s.scl_f;
    scl_fall = ~nscl & s.scl_f;
    // data moving while clock stays high is a bus condition, never data
    start_c  = s.scl_f & nscl & s.sda_f & ~nsda;
    stop_c   = s.scl_f & nscl & ~s.sda_f & nsda;
    match    = (s.sh[7:3] == SLAVE_ADDR_HI) &&
               (s.sh[2] == s.sck_f) && (s.sh[1] == s.sen_f);

    // half-symbol divider and counter; stops at zero, no reload
    if (s.tick == 16'(TICK_CYCLES - 1)) begin
      n.tick = 16'h0000;
      tk     = 1'b1;
    end else begin
      n.tick = s.tick + 16'h0001;
    end
    if (tk && (s.hsym != 16'h0000)) begin
      n.hsym   = s.hsym - 16'h0001;
      tmr_zero = (s.hsym == 16'h0001);
    end

    // two-wire slave; stop and start override any phase
    if (stop_c) begin
      n.st     = I_IDLE;
      n.sda_oe = 1'b0;
    end else if (start_c) begin
      n.st     = I_ADDR;
      n.cnt    = 4'h0;
      n.sda_oe = 1'b0;
    end else begin
      unique case (s.st)
        I_IDLE, I_WAIT: begin
          n.sda_oe = 1'b0;  // ignore bus until next start
        end
        I_ADDR, I_REG, I_WDATA: begin
          if (scl_rise) begin
            n.sh  = {s.sh[6:0], nsda};
            n.cnt = 4'(s.cnt + 4'h1);
          end else if (scl_fall && (s.cnt == 4'h8)) begin
            n.cnt    = 4'h0;
            n.sda_oe = 1'b1;
            if (s.st == I_ADDR) begin
              n.rw = s.sh[0];
              n.st = match ? I_ACK_A : I_WAIT;
              n.sda_oe = match;
            end else if (s.st == I_REG) begin
              n.ptr = s.sh;
              n.st  = I_ACK_R;
            end else begin
              n.st = I_ACK_W;
              if (s.ptr[7:6] == 2'h0) begin
                n = reg_wr(n, s.ptr[5:0], s.sh);
              end
            end
          end
        end
        I_ACK_A: begin
          if (scl_fall) begin
            n.cnt = 4'h0;
            if (s.rw) begin
              // fetch byte and drive its first bit while clock is low
              d        = (s.ptr[7:6] == 2'h0) ? reg_rd(s, s.ptr[5:0]) : 8'h00;
              clr      = (s.ptr == {2'h0, IDX_STATUS});
              n.sh     = d;
              n.sda_oe = ~d[7];
              n.st     = I_RDATA;
            end else begin
              n.sda_oe = 1'b0;
              n.st     = I_REG;
            end
          end
        end
        I_ACK_R: begin
          if (scl_fall) begin
            n.sda_oe = 1'b0;  // a read continues via repeated start
            n.st     = I_WDATA;
          end
        end
        I_ACK_W: begin
          if (scl_fall) begin
            n.sda_oe = 1'b0;  // one byte per write, master stops
            n.st     = I_WAIT;
          end
        end
        I_RDATA: begin
          if (scl_rise) begin
            n.cnt = 4'(s.cnt + 4'h1);
          end else if (scl_fall) begin
            if (s.cnt == 4'h8) begin
              n.sda_oe = 1'b0;
              n.st     = I_RACK;
            end else begin
              n.sh     = {s.sh[6:0], 1'b0};
              n.sda_oe = ~s.sh[6];
            end
          end
        end
        I_RACK: begin
          if (scl_fall) begin
            n.st = I_WAIT;  // master gives no ack, then stops
          end
        end
      endcase
    end

    // apb slave: one wait state, answer registered
    apb_done  = psel_i & penable_i & s.pready;
    n.pready  = psel_i & penable_i & ~s.pready;
    n.pslverr = 1'b0;
    if (psel_i && penable_i && !s.pready) begin
      n.pslverr = ~reg_known(paddr_i[7:2]) | (paddr_i[1:0] != 2'h0);
      if (paddr_i[7:2] == IDX_HDR) begin
        n.prdata = {19'h00000, decode_hdr(s.hdr)};
      end else begin
        n.prdata = {24'h000000, reg_rd(s, paddr_i[7:2])};
      end
    end
    if (apb_done && !s.pslverr) begin
      if (pwrite_i) begin
        n = reg_wr(n, paddr_i[7:2], pwdata_i[7:0]);
        if (paddr_i[7:2] == IDX_HDR) begin
          n.hdr = pwdata_i[11:0];
        end
      end else if (paddr_i[7:2] == IDX_STATUS) begin
        clr = 1'b1;
      end
    end

    // transmit release outcome bits
    if (slot2_done_i) begin
      n.txstat[4] = tx_result_i[4];
      n.txstat[2] = tx_result_i[2];
    end
    if (slot1_done_i) begin
      n.txstat[3] = tx_result_i[3];
      n.txstat[1] = tx_result_i[1];
    end
    if (normal_done_i) begin
      n.txstat[0] = tx_result_i[0];
    end

    // event vector in status order; set beats a clearing read
    ev            = 8'h00;
    ev[BIT_SLEEP] = inactive_start_i;
    ev[BIT_WAKE]  = wakeup_i;
    ev[BIT_TMR]   = tmr_zero;
    ev[BIT_SEC]   = rx_frame_i & rx_secure_i;
    ev[BIT_RX]    = rx_frame_i & rx_filter_pass_i;
    ev[BIT_SLOT2] = slot2_done_i;
    ev[BIT_SLOT1] = slot1_done_i;
    ev[BIT_NORM]  = normal_done_i;
    n.status      = (clr ? STATUS_RST : s.status) | ev;

    // pin follows next flags so it goes inactive with the clearing read
    n.irq = n.pol ? |(n.status & ~n.mask) : ~|(n.status & ~n.mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // register stage and outputs

  // synchronous reset loads constants only
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s <= RESET;
    end else begin
      s <= n;
    end
  end

  assign prdata_o  = s.prdata;
  assign pready_o  = s.pready;
  assign pslverr_o = s.pslverr;
  assign sda_o     = s.sda_out;
  assign sda_oe_o  = s.sda_oe;
  assign irq_o     = s.irq;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  a_event_sets_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ev != 8'h00) |=> ((s.status & $past(ev)) == $past(ev)))
    else $error("event did not set its flag");
  a_irq_unmasked: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (|(s.status & ~s.mask)) |-> (irq_o == s.pol))
    else $error("unmasked flag without active interrupt");
  a_irq_masked_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ((s.status & ~s.mask) == 8'h00) |-> (irq_o == ~s.pol))
    else $error("interrupt active with no unmasked flag");
  a_status_read_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (apb_done && !pwrite_i && !s.pslverr && paddr_i[7:2] == IDX_STATUS)
      |=> (s.status == $past(ev)))
    else $error("status read did not clear flags");
  a_ack_drives_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s.st inside {I_ACK_A, I_ACK_R, I_ACK_W}) |-> (sda_oe_o && !sda_o))
    else $error("acknowledge not driven low");
  a_addr_mismatch: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s.st == I_ADDR && scl_fall && s.cnt == 4'h8 && !match && !start_c && !stop_c)
      |=> (s.st == I_WAIT && !sda_oe_o))
    else $error("foreign address acknowledged");
  a_timer_hits_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (tk && s.hsym == 16'h0001) |=> (s.status[BIT_TMR] && s.hsym != 16'h0001))
    else $error("timer reached zero without flag");
  a_timer_no_reload: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s.hsym == 16'h0000 && !(apb_done && pwrite_i) && s.st != I_WDATA)
      |=> (s.hsym == 16'h0000))
    else $error("timer left zero by itself");
  a_sleep_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    inactive_start_i |=> s.status[BIT_SLEEP])
    else $error("sleep alert flag not raised");
  a_normal_result: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    normal_done_i |=> (s.txstat[0] == $past(tx_result_i[0]) && s.status[BIT_NORM]))
    else $error("normal release outcome not stored");
  a_apb_one_wait: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (psel_i && penable_i && !pready_o) |=> pready_o)
    else $error("apb answer late");
endmodule // host_serial_port_and_irq

//--- tb/i2c_host_model.sv
// two-wire bus master model that stands for the host controller
module i2c_host_model (
  input  wire logic clk_i,     // system clock paces every phase
  input  wire logic sda_i,     // resolved wire level
  output logic      scl_o,     // bus clock, idles high between frames
  output logic      sda_low_o  // high while this model pulls data low
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle bus: clock driven high, data released so the pull-up holds it high
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // data moves only while the clock is low; sampled late in the high phase
  task automatic xfer_bit(input logic b, output logic r);
    sda_low_o <= !b;
    wait_clk(2);
    scl_o <= 1'b1;
    wait_clk(8);
    r = sda_i;
    scl_o <= 1'b0;
    wait_clk(6);
  endtask

  // start, also usable as a repeated start from a low clock
  task automatic start();
    sda_low_o <= 1'b0;
    wait_clk(2);
    scl_o <= 1'b1;
    wait_clk(8);
    sda_low_o <= 1'b1;
    wait_clk(8);
    scl_o <= 1'b0;
    wait_clk(6);
  endtask

  // stop ends the transfer; clock then stands still high
  task automatic stop();
    sda_low_o <= 1'b1;
    wait_clk(2);
    scl_o <= 1'b1;
    wait_clk(8);
    sda_low_o <= 1'b0;
    wait_clk(8);
  endtask

  // msb first, then the ninth clock reads the slave acknowledge
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xfer_bit(d[i], r);
    xfer_bit(1'b1, r);
    ack = !r;
  endtask

  // data released so the slave drives it; nack given when asked
  task automatic recv_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(1'b1, r);
      d[i] = r;
    end
    xfer_bit(nack, r);
  endtask
endmodule  // i2c_host_model

//--- tb/host_serial_port_and_irq_test.sv
// self-checking bench: apb register tasks, event pulses and two-wire traffic
module host_serial_port_and_irq_test
  import hsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TICK = 2;  // short tick keeps the timer run brief

  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        scl;
  logic        host_low;
  logic        sda_oe;
  logic        sda_val;   // level the device puts on the wire while it drives
  logic        sda_w;     // open-drain wire with pull-up
  logic [1:0]  strap;     // address straps: clock pin, enable pin
  logic [8:0]  ev;        // event pulses; bit 8 is a frame with no qualifier
  logic [4:0]  tx_res;
  logic        irq_o;
  logic        ack;
  logic [7:0]  rb;
  logic [31:0] rdat;
  logic        err;
  int          n_errors  = 0;
  int          tests_run = 0;
  logic [11:0] hdr_in  [3] = '{12'h062, 12'hC63, 12'h080};
  logic [31:0] hdr_out [3] = '{32'h10C4, 32'h18C7, 32'h0};

  // a driven level other than low would spoil every acknowledge and every zero read bit
  assign sda_w = (sda_oe ? sda_val : 1'b1) && !host_low;

  // free-running 10 MHz clock
  always #50 clk = ~clk;

  host_serial_port_and_irq #(.TICK_CYCLES(TICK)) u_dut (
    .clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_val), .sda_oe_o(sda_oe), .serial_clock_pin_i(strap[1]),
    .serial_enable_pin_i(strap[0]), .inactive_start_i(ev[7]), .wakeup_i(ev[6]),
    .rx_frame_i(ev[8] | ev[4] | ev[3]), .rx_secure_i(ev[4]),
    .rx_filter_pass_i(ev[3]), .slot2_done_i(ev[2]), .slot1_done_i(ev[1]),
    .normal_done_i(ev[0]), .tx_result_i(tx_res), .irq_o(irq_o));

  i2c_host_model u_host (.clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_low_o(host_low));

  //////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (n_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; pready, read data and error are all taken at one rising edge
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [1:0] lo,
                     input logic [31:0] wd, output logic [31:0] rd, output logic e);
    logic done;
    done = 1'b0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, lo};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    for (int n = 0; n < 20 && !done; n++) begin
      @(posedge clk);
      done = (pready_o === 1'b1);
      rd = prdata_o;
      e = pslverr_o;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    if (!done) begin
      n_errors++;
      wrap_up();
    end
  endtask

  task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic        e;
    apb(1'b0, idx, 2'b00, 32'h0, d, e);
    chk({31'h0, e}, 32'h0);
    chk(d, exp);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    logic [31:0] x;
    logic        e;
    apb(1'b1, idx, 2'b00, d, x, e);
    chk({31'h0, e}, 32'h0);
  endtask

  // one-cycle event pulse, then one edge for the flag to land
  task automatic pulse(input logic [8:0] e);
    ev <= e;
    @(posedge clk);
    ev <= 9'h000;
    @(posedge clk);
  endtask

  // irq is read mid-cycle, after the edge's updates have settled
  task automatic irq_is(input logic v);
    @(negedge clk);
    chk({31'h0, irq_o}, {31'h0, v});
    @(posedge clk);
  endtask

  //////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    strap = 2'b00;
    ev = 9'h000;
    tx_res = 5'h00;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    irq_is(1'b1);
    rd(IDX_STATUS, {24'h0, STATUS_RST});
    rd(IDX_MASK, {24'h0, MASK_RST});
    apb(1'b0, 6'h00, 2'b00, 32'h0, rdat, err);
    chk({31'h0, err}, 32'h1);
    // every source but the timer sets its own flag while masked; a read clears it
    for (int b = 0; b < 8; b++) begin
      if (b != BIT_TMR) begin
        pulse(9'(1 << b));
        irq_is(1'b1);
        rd(IDX_STATUS, 32'(1 << b));
        rd(IDX_STATUS, 32'h0);
      end
    end
    pulse(9'h100);
    rd(IDX_STATUS, 32'h0);
    // status ignores writes and misaligned reads do not clear it
    pulse(9'h040);
    wr(IDX_STATUS, 32'hFF);
    apb(1'b0, IDX_STATUS, 2'b10, 32'h0, rdat, err);
    chk({31'h0, err}, 32'h1);
    rd(IDX_STATUS, 32'h40);
    // mask gates the pin, polarity flips its active level
    wr(IDX_MASK, 32'hBF);
    pulse(9'h080);
    irq_is(1'b1);
    pulse(9'h040);
    irq_is(1'b0);
    rd(IDX_STATUS, 32'hC0);
    irq_is(1'b1);
    wr(IDX_CTRL, 32'h1);
    irq_is(1'b0);
    pulse(9'h040);
    irq_is(1'b1);
    rd(IDX_STATUS, 32'h40);
    // timer: ten ticks down to zero, flag once, no reload
    wr(IDX_TMR_LO, 32'h0A);
    wr(IDX_TMR_HI, 32'h00);
    rd(IDX_STATUS, 32'h0);
    repeat (10 * TICK + 4) @(posedge clk);
    rd(IDX_STATUS, 32'h20);
    rd(IDX_TMR_LO, 32'h0);
    // release outcome bits are taken at each done pulse
    tx_res <= 5'h1F;
    pulse(9'h001);
    rd(IDX_TXSTAT, 32'h01);
    pulse(9'h006);
    rd(IDX_TXSTAT, 32'h1F);
    rd(IDX_STATUS, 32'h07);
    // four-wire header decode: short, long, and a short with its flag set
    for (int i = 0; i < 3; i++) begin
      wr(IDX_HDR, {20'h0, hdr_in[i]});
      rd(IDX_HDR, hdr_out[i]);
    end
    // each strap setting gives its own slave address
    for (int s = 0; s < 4; s++) begin
      strap <= 2'(s);
      repeat (8) @(posedge clk);
      u_host.start();
      u_host.send_byte({SLAVE_ADDR_HI, 2'(s), 1'b0}, ack);
      chk({31'h0, ack}, 32'h1);
      u_host.stop();
    end
    u_host.start();
    u_host.send_byte(8'hC8, ack);
    chk({31'h0, ack}, 32'h0);
    u_host.stop();
    // register write over the two-wire bus
    u_host.start();
    u_host.send_byte(8'hCE, ack);
    u_host.send_byte({2'b00, IDX_MASK}, ack);
    u_host.send_byte(8'h5A, ack);
    chk({31'h0, ack}, 32'h1);
    u_host.stop();
    rd(IDX_MASK, 32'h5A);
    // status read with repeated start clears the flags
    pulse(9'h040);
    u_host.start();
    u_host.send_byte(8'hCE, ack);
    u_host.send_byte({2'b00, IDX_STATUS}, ack);
    u_host.start();
    u_host.send_byte(8'hCF, ack);
    chk({31'h0, ack}, 32'h1);
    u_host.recv_byte(1'b1, rb);
    u_host.stop();
    chk({24'h0, rb}, 32'h40);
    rd(IDX_STATUS, 32'h0);
    wrap_up();
  end
endmodule  // host_serial_port_and_irq_test
